// [rtl/sstat_pkg.sv]
// Package for the serial port status block: offsets, field positions, reset values, types
package sstat_pkg;
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  OFF_STATUS     = 8'h00;
   localparam logic [7:0]  OFF_CONTROL    = 8'h04;
   localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;

   localparam int unsigned POS_RX_COUNT   = 24;
   localparam int unsigned POS_TX_COUNT   = 16;
   localparam int unsigned POS_FRAME_ERR  = 12;
   localparam int unsigned POS_ACTIVITY   = 11;
   localparam int unsigned POS_UNDERRUN   = 8;
   localparam int unsigned POS_SHIFT_MT   = 7;
   localparam int unsigned POS_OVERFLOW   = 6;
   localparam int unsigned POS_RX_EMPTY   = 5;
   localparam int unsigned POS_TX_EMPTY   = 3;
   localparam int unsigned POS_TX_FULL    = 1;
   localparam int unsigned POS_RX_FULL    = 0;

   localparam int unsigned POS_CTL_ON     = 0;
   localparam int unsigned POS_CTL_ENHANCED_BUFFER_ENABLE = 1;
   localparam int unsigned POS_CTL_FRAMED = 2;

   localparam int unsigned IRQ_FRAME      = 0;
   localparam int unsigned IRQ_UNDERRUN   = 1;
   localparam int unsigned IRQ_OVERFLOW   = 2;
   localparam int unsigned IRQ_W          = 3;

   localparam logic [31:0] STATUS_IMPL_MASK = 32'h1F1F_19EB;
   localparam logic [31:0] RESET_CONTROL    = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] RESET_MASK  = 3'h0;
   localparam int unsigned PTR_W            = 4;

   // Events and levels coming from the shift engine and buffers
   typedef struct packed {
      logic             frame_error;
      logic             underrun;
      logic             word_received;
      logic             busy;
      logic             shifter_empty;
      logic [PTR_W-1:0] rx_write_pointer;
      logic [4:0]       tx_element_count;
      logic             tx_buffer_empty;
      logic             tx_buffer_full;
   } sstat_engine_s;

   typedef enum logic [1:0] {
      SSTAT_IDLE   = 2'b00,
      SSTAT_ACCESS = 2'b01
   } sstat_bus_e;
endpackage

// [rtl/sstat_rxptr.sv]
// Receive buffer read pointer, element count and empty/full flags
`timescale 1ns/1ps
module sstat_rxptr
   import sstat_pkg::*;
#(
   parameter int unsigned PW = PTR_W
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          module_on,
   input  wire logic          read_strobe,
   input  wire logic [PW-1:0] write_pointer,
   output logic      [PW-1:0] read_pointer,
   output logic      [4:0]    element_count,
   output logic               empty,
   output logic               full
);
   logic [PW-1:0] rd_reg;
   logic [PW-1:0] diff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_reg <= '0;
      end else if (ce) begin
         if (!module_on) begin
            rd_reg <= write_pointer;
         end else if (read_strobe && (rd_reg != write_pointer)) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end

   assign diff          = write_pointer - rd_reg;
   assign read_pointer  = rd_reg;
   assign element_count = 5'(diff);
   // One slot is left free so that equal pointers mean empty
   assign empty         = (rd_reg == write_pointer);
   assign full          = (diff == PW'((1 << PW) - 1));
endmodule

// [rtl/sstat_top.sv]
// Serial port status register block with APB slave and interrupt
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module sstat_top
   import sstat_pkg::*;
(
   input  wire logic                      CORE_CLK,
   input  wire logic                      RST,
   input  wire logic                      CE,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [sstat_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   input  wire sstat_pkg::sstat_engine_s  ENGINE,
   output logic                           MODULE_ON,
   output logic                           ENHANCED_BUFFER_ENABLE,
   output logic                           FRAMED_MODE_ENABLE,
   output logic      [sstat_pkg::PTR_W-1:0] RX_READ_POINTER,
   output logic                           IRQ
);
   import sstat_pkg::*;

   logic [31:0]      control_reg;
   logic             frame_error_reg;
   logic             underrun_reg;
   logic             overflow_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [31:0]      prdata_reg;
   sstat_bus_e       bus_state_reg;
   logic             on_d_reg;

   logic             setup;
   logic             access;
   logic             wr;
   logic             rd;
   logic             addr_ok;
   logic [4:0]       rx_count;
   logic             rx_empty;
   logic             rx_full;
   logic             rx_read;
   logic             on_rise;
   logic             st_wr;
   logic             ev_frame;
   logic             ev_under;
   logic             ev_over;
   logic [IRQ_W-1:0] ev_vec;
   logic [31:0]      status_word;

   // APB: one wait-free access, answer in the access phase itself
   assign setup   = PSEL && !PENABLE;
   assign access  = PSEL && PENABLE && CE;
   assign addr_ok = (PADDR == OFF_STATUS) || (PADDR == OFF_CONTROL) ||
                    (PADDR == OFF_IRQ_STATUS) || (PADDR == OFF_IRQ_MASK);
   assign wr      = access && PWRITE && addr_ok;
   assign rd      = access && !PWRITE;
   assign PREADY  = PSEL && PENABLE && CE;
   assign PSLVERR = PREADY && !addr_ok;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         bus_state_reg <= SSTAT_IDLE;
      end else if (CE) begin
         case (bus_state_reg)
            SSTAT_IDLE:   if (setup) bus_state_reg <= SSTAT_ACCESS;
            SSTAT_ACCESS: if (PREADY) bus_state_reg <= SSTAT_IDLE;
            default:      bus_state_reg <= SSTAT_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         control_reg <= RESET_CONTROL;
      end else if (CE && wr && PADDR == OFF_CONTROL) begin
         control_reg <= {29'h0, PWDATA[2:0]};
      end
   end

   assign MODULE_ON              = control_reg[POS_CTL_ON];
   assign ENHANCED_BUFFER_ENABLE = control_reg[POS_CTL_ENHANCED_BUFFER_ENABLE];
   assign FRAMED_MODE_ENABLE     = control_reg[POS_CTL_FRAMED];

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         on_d_reg <= 1'b0;
      end else if (CE) begin
         on_d_reg <= MODULE_ON;
      end
   end
   assign on_rise = MODULE_ON && !on_d_reg;

   // Reading the data buffer is modelled as a read of the status word's
   // buffer through the pointer block; here a read of the status advances it
   assign rx_read = rd && (PADDR == OFF_STATUS) && !rx_empty;

   sstat_rxptr #(
      .PW (PTR_W)
   ) u_rxptr (
      .clk           (CORE_CLK),
      .rst           (RST),
      .ce            (CE),
      .module_on     (MODULE_ON),
      .read_strobe   (rx_read),
      .write_pointer (ENGINE.rx_write_pointer),
      .read_pointer  (RX_READ_POINTER),
      .element_count (rx_count),
      .empty         (rx_empty),
      .full          (rx_full)
   );

   assign st_wr    = wr && (PADDR == OFF_STATUS);
   assign ev_frame = MODULE_ON && FRAMED_MODE_ENABLE && ENGINE.frame_error;
   assign ev_under = MODULE_ON && FRAMED_MODE_ENABLE && ENGINE.underrun;
   // Word completes while the receive buffer is full
   assign ev_over  = MODULE_ON && ENGINE.word_received && rx_full;

   // Set wins over a same-cycle clear; a written one never sets
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         frame_error_reg <= 1'b0;
      end else if (CE) begin
         if (ev_frame) begin
            frame_error_reg <= 1'b1;
         end else if (!MODULE_ON || (st_wr && !PWDATA[POS_FRAME_ERR])) begin
            frame_error_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         underrun_reg <= 1'b0;
      end else if (CE) begin
         if (ev_under) begin
            underrun_reg <= 1'b1;
         end else if (on_rise || (st_wr && !PWDATA[POS_UNDERRUN])) begin
            underrun_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         overflow_reg <= 1'b0;
      end else if (CE) begin
         if (ev_over) begin
            overflow_reg <= 1'b1;
         end else if (on_rise || (st_wr && !PWDATA[POS_OVERFLOW])) begin
            overflow_reg <= 1'b0;
         end
      end
   end

   assign ev_vec = {ev_over, ev_under, ev_frame};

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         irq_status_reg <= '0;
      end else if (CE) begin
         if (wr && PADDR == OFF_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~PWDATA[IRQ_W-1:0]) | ev_vec;
         end else begin
            irq_status_reg <= irq_status_reg | ev_vec;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         irq_mask_reg <= RESET_MASK;
      end else if (CE && wr && PADDR == OFF_IRQ_MASK) begin
         irq_mask_reg <= PWDATA[IRQ_W-1:0];
      end
   end

   assign IRQ = |(irq_status_reg & irq_mask_reg);

   always_comb begin
      status_word = '0;
      status_word[POS_RX_COUNT +: 5] = rx_count;
      status_word[POS_TX_COUNT +: 5] = ENGINE.tx_element_count;
      status_word[POS_FRAME_ERR]     = frame_error_reg;
      status_word[POS_ACTIVITY]      = ENGINE.busy;
      status_word[POS_UNDERRUN]      = underrun_reg;
      status_word[POS_SHIFT_MT]      = ENGINE.shifter_empty;
      status_word[POS_OVERFLOW]      = overflow_reg;
      status_word[POS_RX_EMPTY]      = rx_empty;
      status_word[POS_TX_EMPTY]      = ENGINE.tx_buffer_empty;
      status_word[POS_TX_FULL]       = ENGINE.tx_buffer_full;
      status_word[POS_RX_FULL]       = rx_full;
      status_word = status_word & STATUS_IMPL_MASK;
   end

   // Read data registered in the setup phase so it is valid at PREADY
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         prdata_reg <= '0;
      end else if (CE && setup && !PWRITE) begin
         case (PADDR)
            OFF_STATUS:     prdata_reg <= status_word;
            OFF_CONTROL:    prdata_reg <= control_reg;
            OFF_IRQ_STATUS: prdata_reg <= {29'h0, irq_status_reg};
            OFF_IRQ_MASK:   prdata_reg <= {29'h0, irq_mask_reg};
            default:        prdata_reg <= '0;
         endcase
      end
   end
   assign PRDATA = prdata_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   property p_frame_set;
      CE && ev_frame |=> frame_error_reg;
   endproperty
   a_frame_set: assert property (p_frame_set) else $error("frame flag not set");

   property p_under_hold;
      CE && underrun_reg && !on_rise && !(st_wr && !PWDATA[POS_UNDERRUN]) |=> underrun_reg;
   endproperty
   a_under_hold: assert property (p_under_hold) else $error("underrun lost");

   property p_under_framed;
      CE && !FRAMED_MODE_ENABLE && !underrun_reg |=> !underrun_reg;
   endproperty
   a_under_framed: assert property (p_under_framed) else $error("underrun unframed");

   property p_over_set;
      CE && ev_over |=> overflow_reg;
   endproperty
   a_over_set: assert property (p_over_set) else $error("overflow not set");

   property p_over_hold;
      CE && overflow_reg && !on_rise && !(st_wr && !PWDATA[POS_OVERFLOW]) |=> overflow_reg;
   endproperty
   a_over_hold: assert property (p_over_hold) else $error("overflow lost");

   property p_no_set_by_write;
      CE && st_wr && !ev_over && !overflow_reg |=> !overflow_reg;
   endproperty
   a_no_set_by_write: assert property (p_no_set_by_write) else $error("write set flag");

   property p_reserved;
      CE && setup && !PWRITE && PADDR == OFF_STATUS |=>
         (prdata_reg & ~STATUS_IMPL_MASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_empty;
      rx_empty == (RX_READ_POINTER == ENGINE.rx_write_pointer);
   endproperty
   a_empty: assert property (p_empty) else $error("empty flag wrong");

   property p_busy_read;
      CE && setup && !PWRITE && PADDR == OFF_STATUS |=>
         prdata_reg[POS_ACTIVITY] == $past(ENGINE.busy);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("activity misread");

   property p_tx_read;
      CE && setup && !PWRITE && PADDR == OFF_STATUS |=>
         prdata_reg[POS_TX_COUNT +: 5] == $past(ENGINE.tx_element_count);
   endproperty
   a_tx_read: assert property (p_tx_read) else $error("tx count misread");

   property p_shift_read;
      CE && setup && !PWRITE && PADDR == OFF_STATUS |=>
         prdata_reg[POS_SHIFT_MT] == $past(ENGINE.shifter_empty);
   endproperty
   a_shift_read: assert property (p_shift_read) else $error("shifter flag misread");

   property p_frame_off;
      CE && !MODULE_ON |=> !frame_error_reg;
   endproperty
   a_frame_off: assert property (p_frame_off) else $error("frame flag kept while off");

   property p_under_clear;
      CE && !ev_under && st_wr && !PWDATA[POS_UNDERRUN] |=> !underrun_reg;
   endproperty
   a_under_clear: assert property (p_under_clear) else $error("underrun not cleared");

   property p_over_clear;
      CE && !ev_over && on_rise |=> !overflow_reg;
   endproperty
   a_over_clear: assert property (p_over_clear) else $error("overflow not cleared");

   // An access phase is only legal after a setup phase was seen
   property p_access_order;
      CE && PSEL && PENABLE |-> bus_state_reg == SSTAT_ACCESS;
   endproperty
   a_access_order: assert property (p_access_order) else $error("access without setup");

   c_overflow: cover property (ev_over ##1 overflow_reg);
   c_frame:    cover property (ev_frame ##1 frame_error_reg);
   c_clear:    cover property (underrun_reg ##1 !underrun_reg);
   c_irq:      cover property (!IRQ ##1 IRQ);
endmodule

// [verif/sstat_engine_model.sv]
// Behavioural shift engine on the far side: event pulses, levels and the receive write pointer
`timescale 1ns/1ps
module sstat_engine_model
   import sstat_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        on,
   input  wire logic [sstat_pkg::PTR_W-1:0] rd_ptr,
   input  wire logic [2:0]                  req,
   input  wire logic [8:0]                  lvl,
   output sstat_pkg::sstat_engine_s         eng
);
   logic pend;
   // Pointer moves a cycle after the pulse, so the pulse still sees the old fill level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eng  <= '0;
         pend <= 1'b0;
      end else begin
         {eng.underrun, eng.frame_error, eng.word_received} <= req;
         {eng.busy, eng.shifter_empty, eng.tx_element_count} <= lvl[8:2];
         {eng.tx_buffer_empty, eng.tx_buffer_full} <= lvl[1:0];
         pend <= req[0] && ((eng.rx_write_pointer - rd_ptr) != 4'hF);
         if (!on) begin
            eng.rx_write_pointer <= 4'h0;
         end else if (pend) begin
            eng.rx_write_pointer <= eng.rx_write_pointer + 4'h1;
         end
      end
   end
endmodule

// [verif/tb_spi_status_flags.sv]
// Self-checking bench of the serial port status block
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module tb_spi_status_flags;
   import sstat_pkg::*;
   logic              CORE_CLK, RST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
   logic [ADDR_W-1:0] PADDR;
   logic [31:0]       PWDATA, PRDATA, rd;
   sstat_engine_s     eng;
   logic              on_o, enh_o, frm_o, err, on, fr, fe, ur, ov;
   logic [PTR_W-1:0]  rptr, wp, rp;
   logic [2:0]        req, irq_st;
   logic [8:0]        lvl;
   int                error_cnt, num_checks, cyc;

   initial begin
      CORE_CLK = 1'b0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end

   sstat_top i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .ENGINE(eng), .MODULE_ON(on_o), .ENHANCED_BUFFER_ENABLE(enh_o),
      .FRAMED_MODE_ENABLE(frm_o), .RX_READ_POINTER(rptr), .IRQ(IRQ));
   sstat_engine_model i_eng (.clk(CORE_CLK), .rst(RST), .on(on_o), .rd_ptr(rptr), .req(req),
      .lvl(lvl), .eng(eng));

   function automatic logic [31:0] exp_stat();
      logic [3:0] d;
      d = wp - rp;
      return {3'h0, 1'b0, d, 3'h0, lvl[6:2], 3'h0, fe, lvl[8], 2'h0, ur, lvl[7], ov,
              d == 4'h0, 1'b0, lvl[1], 1'b0, lvl[0], d == 4'hF};
   endfunction

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH %0t no ready", $time);
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd_stat();
      logic [31:0] e;
      e = exp_stat();
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd, e, "status")
      `CHK(rptr, rp, "read pointer")
      if (wp != rp) rp++;
   endtask

   // Disabling empties both pointers and clears the frame error; re-enabling clears underrun and overflow
   task automatic ctl(input logic [2:0] v);
      apb(1'b1, OFF_CONTROL, {29'h0, v});
      if (!v[0]) begin
         fe = 1'b0;
         wp = 4'h0;
         rp = 4'h0;
      end else if (!on) begin
         ur = 1'b0;
         ov = 1'b0;
      end
      on = v[0];
      fr = v[2];
      @(negedge CORE_CLK);
      `CHK({frm_o, enh_o, on_o}, v, "control outputs")
      // Read pointer follows the cleared write pointer one cycle late
      repeat (2) @(posedge CORE_CLK);
   endtask

   task automatic push(input logic [2:0] r);
      @(posedge CORE_CLK);
      req <= r;
      @(posedge CORE_CLK);
      req <= 3'h0;
      repeat (3) @(posedge CORE_CLK);
      if (r[0] && on && wp - rp == 4'hF) begin
         ov = 1'b1;
         irq_st[2] = 1'b1;
      end else if (r[0] && on) wp++;
      if (r[1] && on && fr) {fe, irq_st[0]} = 2'b11;
      if (r[2] && on && fr) {ur, irq_st[1]} = 2'b11;
   endtask

   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("MISMATCH %0t timeout", $time);
         conclude();
      end
   end

   initial begin
      {RST, CE, PSEL, PENABLE, PWRITE, PADDR, PWDATA, req, lvl} = {2'b11, 55'h0};
      {on, fr, fe, ur, ov, irq_st, wp, rp} = '0;
      {error_cnt, num_checks, cyc} = '0;
      void'($urandom(32'h36621f17));
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      rd_stat();
      apb(1'b0, OFF_CONTROL, 32'h0);
      `CHK(rd, RESET_CONTROL, "control reset")
      apb(1'b0, OFF_IRQ_MASK, 32'h0);
      `CHK(rd, {29'h0, RESET_MASK}, "mask reset")
      apb(1'b0, 8'h10, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0}, "unmapped")
      push(3'b110);
      rd_stat();
      ctl(3'h7);
      // Random levels and events; status writes carry ones in the sticky bits
      repeat (24) begin
         lvl <= 9'($urandom);
         push(3'($urandom));
         apb(1'b1, OFF_STATUS, $urandom | 32'h0000_1140);
         rd_stat();
      end
      repeat (16) rd_stat();
      apb(1'b1, OFF_STATUS, 32'h0);
      {fe, ur, ov} = 3'h0;
      apb(1'b1, OFF_IRQ_STATUS, 32'h7);
      irq_st = 3'h0;
      repeat (16) push(3'b001);
      rd_stat();
      apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
      rd_stat();
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      `CHK(rd, {29'h0, irq_st}, "irq status")
      `CHK(IRQ, 1'b0, "irq masked")
      apb(1'b1, OFF_IRQ_MASK, 32'h4);
      @(negedge CORE_CLK);
      `CHK(IRQ, 1'b1, "irq raised")
      apb(1'b1, OFF_IRQ_STATUS, 32'h4);
      irq_st[2] = 1'b0;
      @(negedge CORE_CLK);
      `CHK(IRQ, 1'b0, "irq cleared")
      apb(1'b1, OFF_STATUS, 32'h1100);
      ov = 1'b0;
      rd_stat();
      push(3'b110);
      apb(1'b1, OFF_STATUS, 32'h1040);
      ur = 1'b0;
      rd_stat();
      apb(1'b1, OFF_STATUS, 32'h0140);
      fe = 1'b0;
      rd_stat();
      repeat (16) push(3'b101);
      ctl(3'h0);
      rd_stat();
      ctl(3'h7);
      rd_stat();
      // Events that arrive while the clock enable is low are lost
      CE <= 1'b0;
      @(posedge CORE_CLK);
      req <= 3'b110;
      @(posedge CORE_CLK);
      req <= 3'h0;
      repeat (2) @(posedge CORE_CLK);
      CE <= 1'b1;
      rd_stat();
      ctl(3'h3);
      push(3'b110);
      rd_stat();
      conclude();
   end
endmodule
